// File: aics_ctrl_slave.v
// Slave-only two-wire control port with subaddress framing and write commit
`timescale 1ns/10ps
`include "aics_regs.vh"
// Function
// - Works at 100 kHz and 400 kHz
// - Slave only, never stretches clock
// - Bytes of eight bits, MSB first
// - Receiver acknowledges each byte next clock
// - Detect start and stop on data edges
// - Change data only while clock low
// - Hold data low through acknowledge period
// - Address follows the address-select strap
// - Write to address register changes address only after the unlock key is written
// - No limit on bytes per transaction
// - Low subaddresses take single-byte access
// - Wide subaddresses take four-byte multiples
// - Read continues while master acknowledges
// - Unused bits of short registers read zero
// - Count written bytes against subaddress length
// - Stop or restart discards partial data
// - Sequential write advances subaddress per set
// - Keep complete sets, drop incomplete last
// - Single write: address, subaddress, data, stop
// - Read: subaddress, restart, read, final nack
// - Strap sampled after each reset sets the starting address
module aics_ctrl_slave (
  input wire clk_sys,                    // System clock, 250 MHz
  input wire reset,                      // Asynchronous reset, active high
  input wire scl_in,                     // Bus clock pin level
  input wire sda_in,                     // Bus data pin level
  output wire sda_out,                   // Data drive value, always low
  output wire sda_oe,                    // High while pulling data low
  input wire addr_sel_in,                // Address-select strap pin
  output wire [6:0] bus_addr,            // Current 7-bit bus address
  output wire [7:0] rd_sub,              // Subaddress being read
  output wire [2:0] rd_word_idx,         // Word within a multi-word register
  input wire [31:0] rd_data,             // Word of that subaddress
  input wire [5:0] rd_width,             // Implemented bits of that word
  output wire wr_strobe,                 // One-cycle commit pulse
  output wire [7:0] wr_sub,              // Committed subaddress
  output wire [4:0] wr_len,              // Committed byte count
  output wire [`AICS_WR_BITS-1:0] wr_data // Committed bytes, last in low byte
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_SUB = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_ACK = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_MACK = 3'h6;

  // Third stage of each bus line only serves edge detection
  reg scl_s1_reg;
  reg scl_s2_reg;
  reg scl_s3_reg;
  reg sda_s1_reg;
  reg sda_s2_reg;
  reg sda_s3_reg;
  reg sel_s1_reg;
  reg sel_s2_reg;
  reg [1:0] strap_cnt_reg;
  reg strap_done_reg;
  reg [6:0] addr_reg;
  reg unlock_reg;
  reg [2:0] state_reg;
  reg [2:0] after_reg;
  reg [3:0] bitcnt_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  reg [7:0] sub_reg;
  reg [4:0] cnt_reg;
  reg oe_reg;
  reg mack_reg;
  reg sda_out_reg;
  // Sized for the widest set, five filter words, so no set is ever cut
  reg [`AICS_WR_BITS-1:0] shift_reg;
  reg wr_strobe_reg;
  reg [7:0] wr_sub_reg;
  reg [4:0] wr_len_reg;
  reg [`AICS_WR_BITS-1:0] wr_data_reg;

  wire scl_rise = scl_s2_reg & ~scl_s3_reg;
  wire scl_fall = ~scl_s2_reg & scl_s3_reg;
  // Data edge while clock stays high is a bus condition
  wire start_det = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  wire stop_det = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  wire [4:0] cnt_inc = cnt_reg + 5'h01;
  wire [7:0] sub_inc = sub_reg + 8'h01;
  wire [4:0] cur_len;
  wire [`AICS_WR_BITS-1:0] shift_next;
  wire [31:0] rd_src;
  wire [7:0] rd_byte;

  // Bytes each subaddress needs before it may be committed
  function [4:0] len_of;
    input [7:0] sub;
    begin
      if (sub < `AICS_SUB_WIDE_BASE)
        len_of = `AICS_LEN_SHORT;
      else if (sub >= `AICS_SUB_BIQUAD_FIRST && sub <= `AICS_SUB_BIQUAD_LAST)
        len_of = `AICS_LEN_BIQUAD;
      else
        len_of = `AICS_LEN_WORD;
    end
  endfunction

  // Picks the byte to send, unimplemented bits forced to zero
  function [7:0] pick_byte;
    input [31:0] word;
    input [5:0] width;
    input [4:0] cnt;
    input is_short;
    reg [31:0] masked;
    begin
      if (width >= 6'h20)
        masked = word;
      else
        masked = word & ~({32{1'b1}} << width);
      if (is_short)
        pick_byte = masked[7:0];
      else
        case (cnt[1:0])
          2'h0: pick_byte = masked[31:24];
          2'h1: pick_byte = masked[23:16];
          2'h2: pick_byte = masked[15:8];
          default: pick_byte = masked[7:0];
        endcase
    end
  endfunction

  // Address-change word lives here, not in the outside register file
  function is_addr_word;
    input [7:0] sub;
    begin
      is_addr_word = (sub == `AICS_SUB_BUS_ADDR);
    end
  endfunction

  assign cur_len = len_of(sub_reg);
  // Fresh set starts from a cleared buffer so short writes carry no stale bytes
  assign shift_next = (cnt_reg == 5'h00) ? {{(`AICS_WR_BITS-8){1'b0}}, rx_reg} :
                      {shift_reg[`AICS_WR_BITS-9:0], rx_reg};
  assign rd_src = is_addr_word(sub_reg) ? {24'h00_0000, addr_reg, 1'b0} : rd_data;
  // Read data must settle within one bus clock period; no wait states hide it
  assign rd_byte = pick_byte(rd_src,
                             is_addr_word(sub_reg) ? 6'h20 : rd_width,
                             cnt_reg, cur_len == `AICS_LEN_SHORT);

  // Open drain: the pin is only ever pulled low, so the value flop is constant
  assign sda_out = sda_out_reg;
  assign sda_oe = oe_reg;
  assign bus_addr = addr_reg;
  assign rd_sub = sub_reg;
  assign rd_word_idx = cnt_reg[4:2];
  assign wr_strobe = wr_strobe_reg;
  assign wr_sub = wr_sub_reg;
  assign wr_len = wr_len_reg;
  assign wr_data = wr_data_reg;

  // Pins pass two flops; 4 ns sampling resolves 400 kHz edges easily
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end else begin
      // Clock line is only sampled, never driven, so it is never stretched
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      sel_s1_reg <= addr_sel_in;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      addr_reg <= `AICS_ADDR_SEL_LO;
      unlock_reg <= 1'b0;
      state_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      sub_reg <= 8'h00;
      cnt_reg <= 5'h00;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      shift_reg <= {`AICS_WR_BITS{1'b0}};
      wr_strobe_reg <= 1'b0;
      wr_sub_reg <= 8'h00;
      wr_len_reg <= 5'h00;
      wr_data_reg <= {`AICS_WR_BITS{1'b0}};
    end else begin
      wr_strobe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      if (!strap_done_reg) begin
        // Strap is taken once, after it has crossed the synchroniser
        if (strap_cnt_reg == `AICS_STRAP_WAIT) begin
          strap_done_reg <= 1'b1;
          addr_reg <= sel_s2_reg ? `AICS_ADDR_SEL_HI : `AICS_ADDR_SEL_LO;
        end else begin
          strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end
      end else if (start_det) begin
        // Restart drops any unfinished set but keeps the subaddress for reads
        state_reg <= ST_ADDR;
        bitcnt_reg <= 4'h0;
        cnt_reg <= 5'h00;
        oe_reg <= 1'b0;
      end else if (stop_det) begin
        // Stop ends the frame; an unfinished set is simply dropped
        state_reg <= ST_IDLE;
        cnt_reg <= 5'h00;
        oe_reg <= 1'b0;
      end else if (scl_rise) begin
        case (state_reg)
          ST_ADDR, ST_SUB, ST_WDATA: begin
            if (bitcnt_reg < 4'h8) begin
              rx_reg <= {rx_reg[6:0], sda_s2_reg};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
          ST_MACK: begin
            // Master's answer is taken at the clock rise, where it is settled
            mack_reg <= ~sda_s2_reg;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        // All drive changes happen on clock fall, never while it is high
        case (state_reg)
          ST_ADDR: begin
            if (bitcnt_reg == 4'h8) begin
              if (rx_reg[7:1] == addr_reg) begin
                oe_reg <= 1'b1;
                state_reg <= ST_ACK;
                after_reg <= rx_reg[0] ? ST_RDATA : ST_SUB;
              end else begin
                // Foreign address: stay off the bus until the next start
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_SUB: begin
            if (bitcnt_reg == 4'h8) begin
              sub_reg <= rx_reg;
              cnt_reg <= 5'h00;
              oe_reg <= 1'b1;
              state_reg <= ST_ACK;
              after_reg <= ST_WDATA;
            end
          end
          ST_WDATA: begin
            if (bitcnt_reg == 4'h8) begin
              shift_reg <= shift_next;
              if (cnt_inc == cur_len) begin
                wr_strobe_reg <= 1'b1;
                wr_sub_reg <= sub_reg;
                wr_len_reg <= cur_len;
                wr_data_reg <= shift_next;
                sub_reg <= sub_inc;
                cnt_reg <= 5'h00;
                if (sub_reg == `AICS_SUB_ADDR_EN)
                  unlock_reg <= (shift_next[31:0] == `AICS_ADDR_EN_KEY);
                // Unlock is spent by the next address write, wanted or not
                if (is_addr_word(sub_reg)) begin
                  if (unlock_reg)
                    addr_reg <= shift_next[7:1];
                  unlock_reg <= 1'b0;
                end
              end else begin
                cnt_reg <= cnt_inc;
              end
              oe_reg <= 1'b1;
              state_reg <= ST_ACK;
              after_reg <= ST_WDATA;
            end
          end
          ST_ACK: begin
            bitcnt_reg <= 4'h0;
            if (after_reg == ST_RDATA) begin
              tx_reg <= {rd_byte[6:0], 1'b0};
              oe_reg <= ~rd_byte[7];
              bitcnt_reg <= 4'h1;
              state_reg <= ST_RDATA;
            end else begin
              oe_reg <= 1'b0;
              state_reg <= after_reg;
            end
          end
          ST_RDATA: begin
            if (bitcnt_reg == 4'h8) begin
              // Release for the master's answer and step to the next byte
              oe_reg <= 1'b0;
              state_reg <= ST_MACK;
              if (cnt_inc == cur_len) begin
                sub_reg <= sub_inc;
                cnt_reg <= 5'h00;
              end else begin
                cnt_reg <= cnt_inc;
              end
            end else begin
              oe_reg <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
          ST_MACK: begin
            if (mack_reg) begin
              tx_reg <= {rd_byte[6:0], 1'b0};
              oe_reg <= ~rd_byte[7];
              bitcnt_reg <= 4'h1;
              state_reg <= ST_RDATA;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// File: aics_master.sv
// Behavioural two-wire bus master driving the slave
`timescale 1ns/10ps
module aics_master (
  input wire clk,               // Bench system clock
  input wire sda,               // Resolved data wire
  output reg scl_oe = 1'b0,     // High pulls clock low
  output reg sda_oe = 1'b0      // High pulls data low
);
  // Quarter bus period of 5 clocks gives the 80 ns bus clock
  task clk_bit(input b, output r);
    begin
      repeat (5) @(negedge clk);
      sda_oe = ~b;
      repeat (5) @(negedge clk);
      scl_oe = 1'b0;
      repeat (5) @(negedge clk);
      r = sda;
      repeat (5) @(negedge clk);
      scl_oe = 1'b1;
    end
  endtask
  task start;
    begin
      repeat (5) @(negedge clk);
      sda_oe = 1'b1;
      repeat (5) @(negedge clk);
      scl_oe = 1'b1;
    end
  endtask
  task restart;
    begin
      repeat (5) @(negedge clk);
      sda_oe = 1'b0;
      repeat (5) @(negedge clk);
      scl_oe = 1'b0;
      start;
    end
  endtask
  task stop;
    begin
      repeat (5) @(negedge clk);
      sda_oe = 1'b1;
      repeat (5) @(negedge clk);
      scl_oe = 1'b0;
      repeat (5) @(negedge clk);
      sda_oe = 1'b0;
      repeat (10) @(negedge clk);
    end
  endtask
  task xfer(input [7:0] dv, input ab, output [7:0] qv, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i--) clk_bit(dv[i], qv[i]);
      clk_bit(ab, r);
      ack = ~r;
    end
  endtask
endmodule

// File: aics_monitor.sv
// Port-level assertions for the control-port slave
`timescale 1ns/10ps
`include "aics_regs.vh"
module aics_monitor (
  input wire clk_sys,                    // System clock
  input wire reset,                      // Asynchronous reset
  input wire scl_in,                     // Bus clock level
  input wire sda_oe,                     // Data pull-down enable
  input wire addr_sel_in,                // Address strap
  input wire [6:0] bus_addr,             // Current address
  input wire wr_strobe,                  // Commit pulse
  input wire [7:0] wr_sub,               // Committed subaddress
  input wire [4:0] wr_len,               // Committed length
  input wire [`AICS_WR_BITS-1:0] wr_data // Committed bytes
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_out_of_reset;
    $fell(reset);
  endsequence
  sequence s_strap_taken;
    ##[3:6] bus_addr == (addr_sel_in ? `AICS_ADDR_SEL_HI : `AICS_ADDR_SEL_LO);
  endsequence
  a_strap_addr: assert property (s_out_of_reset |-> s_strap_taken)
    else $error("strap address not taken");
  a_reset_addr: assert property (s_out_of_reset |-> bus_addr == `AICS_ADDR_SEL_LO && !sda_oe)
    else $error("address or drive wrong at reset release");
  a_drive_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("data pull-down released early");
  a_strobe_ack: assert property (wr_strobe |-> ##[0:2] sda_oe)
    else $error("committed byte not acknowledged");
  a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
    else $error("commit pulse longer than one cycle");
  a_len_short: assert property (wr_strobe && wr_sub < `AICS_SUB_WIDE_BASE |->
    wr_len == `AICS_LEN_SHORT)
    else $error("short subaddress length wrong");
  a_len_biquad: assert property (wr_strobe && wr_sub >= `AICS_SUB_BIQUAD_FIRST &&
    wr_sub <= `AICS_SUB_BIQUAD_LAST |-> wr_len == `AICS_LEN_BIQUAD)
    else $error("filter subaddress length wrong");
  a_len_wide: assert property (wr_strobe && wr_sub >= `AICS_SUB_WIDE_BASE &&
    !(wr_sub >= `AICS_SUB_BIQUAD_FIRST && wr_sub <= `AICS_SUB_BIQUAD_LAST) |->
    wr_len == `AICS_LEN_WORD)
    else $error("wide subaddress length wrong");
  a_pad_zero: assert property (wr_strobe && wr_len == `AICS_LEN_SHORT |->
    wr_data[`AICS_WR_BITS-1:8] == 0)
    else $error("single-byte commit carries stale bytes");
endmodule
bind aics_ctrl_slave aics_monitor u_mon (.clk_sys, .reset, .scl_in, .sda_oe, .addr_sel_in,
  .bus_addr, .wr_strobe, .wr_sub, .wr_len, .wr_data);

// File: aics_regs.vh
// Constants of the amplifier control-port slave: addresses, subaddresses, lengths
`ifndef AICS_REGS_VH
`define AICS_REGS_VH

// Bus address chosen by the address-select strap
`define AICS_ADDR_SEL_HI 7'h1b
`define AICS_ADDR_SEL_LO 7'h1a

// Subaddress map
`define AICS_SUB_ADDR_EN 8'hf8
`define AICS_SUB_BUS_ADDR 8'hf9
`define AICS_SUB_WIDE_BASE 8'h20
`define AICS_SUB_BIQUAD_FIRST 8'h29
`define AICS_SUB_BIQUAD_LAST 8'h36

// Unlock pattern for the address-change enable register
`define AICS_ADDR_EN_KEY 32'hf9a5_a5a5

// Bytes per subaddress
`define AICS_LEN_SHORT 5'h01
`define AICS_LEN_WORD 5'h04
`define AICS_LEN_BIQUAD 5'h14

// Data width of the widest write (five 32-bit words)
`define AICS_WR_BITS 160

// Cycles after reset release before the strap is taken (sync depth plus one)
`define AICS_STRAP_WAIT 2'h3

`endif

// File: testbench.sv
// Self-checking bench for the control-port slave
`timescale 1ns/10ps
`include "aics_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg addr_sel_in = 1'b0;
  wire scl_oe_m, sda_oe_m, sda_out, sda_oe, wr_strobe;
  wire scl_in = ~scl_oe_m;
  wire sda_in = ~(sda_oe_m | sda_oe);
  wire [6:0] bus_addr;
  wire [7:0] rd_sub, wr_sub;
  wire [2:0] rd_word_idx;
  wire [4:0] wr_len;
  wire [`AICS_WR_BITS-1:0] wr_data;
  wire [31:0] rd_data = {8'hc3, rd_sub, 5'h00, rd_word_idx, ~rd_sub};
  // Subaddress 0x05 models a 4-bit register
  wire [5:0] rd_width = (rd_sub == 8'h05) ? 6'h04 : 6'h20;
  integer check_count = 0, miscompares = 0, strobes = 0, k;
  reg ack;
  reg [7:0] d;
  reg [7:0] q[$];
  reg [7:0] rq[$];
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wr_strobe === 1'b1) strobes <= strobes + 1;
  aics_master u_mst (.clk(clk_sys), .sda(sda_in), .scl_oe(scl_oe_m), .sda_oe(sda_oe_m));
  aics_ctrl_slave u_dut (.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_in(addr_sel_in), .bus_addr(bus_addr),
    .rd_sub(rd_sub), .rd_word_idx(rd_word_idx), .rd_data(rd_data), .rd_width(rd_width),
    .wr_strobe(wr_strobe), .wr_sub(wr_sub), .wr_len(wr_len), .wr_data(wr_data));
  task wr(input [6:0] a, input [7:0] s);
    integer i;
    begin
      u_mst.start;
      u_mst.xfer({a, 1'b0}, 1'b1, d, ack);
      if (ack) begin
        u_mst.xfer(s, 1'b1, d, ack);
        for (i = 0; i < q.size(); i++) u_mst.xfer(q[i], 1'b1, d, ack);
      end
      u_mst.stop;
    end
  endtask
  task rd(input [7:0] s, input integer n);
    integer i;
    begin
      rq = {};
      u_mst.start;
      u_mst.xfer({`AICS_ADDR_SEL_HI, 1'b0}, 1'b1, d, ack);
      u_mst.xfer(s, 1'b1, d, ack);
      u_mst.restart;
      u_mst.xfer({`AICS_ADDR_SEL_HI, 1'b1}, 1'b1, d, ack);
      for (i = 0; i < n; i++) begin
        u_mst.xfer(8'hff, i == n - 1, d, ack);
        rq.push_back(d);
      end
      u_mst.stop;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    conclude;
  end
  initial begin
    for (k = 0; k < 2; k++) begin
      reset = 1'b1;
      addr_sel_in = k[0];
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      repeat (12) @(negedge clk_sys);
      `CHK("bus_addr", k ? `AICS_ADDR_SEL_HI : `AICS_ADDR_SEL_LO, bus_addr)
    end
    q = {8'h5c};
    wr(`AICS_ADDR_SEL_LO, 8'h03);
    `CHK("foreign", {1'b0, 32'h0000_0000}, {ack, strobes})
    `CHK("sda_out", 1'b0, sda_out)
    wr(`AICS_ADDR_SEL_HI, 8'h03);
    `CHK("single", {1'b1, 8'h03, 5'h01, 8'h5c}, {ack, wr_sub, wr_len, wr_data[7:0]})
    q = {8'h11, 8'h22, 8'h33};
    wr(`AICS_ADDR_SEL_HI, 8'h1e);
    `CHK("seq", {32'h0000_0003, 8'h1f, 8'h22}, {strobes, wr_sub, wr_data[7:0]})
    q = {};
    for (k = 0; k < 22; k++) q.push_back(k + 1);
    wr(`AICS_ADDR_SEL_HI, 8'h29);
    `CHK("biquad", {8'h29, 5'h14, 32'h1112_1314}, {wr_sub, wr_len, wr_data[31:0]})
    q = {8'hde, 8'had, 8'hbe, 8'hef};
    wr(`AICS_ADDR_SEL_HI, 8'h21);
    `CHK("wide", {32'h0000_0005, 5'h04, 32'hdead_beef}, {strobes, wr_len, wr_data[31:0]})
    rd(8'h05, 2);
    `CHK("rd_short", 16'h0af9, {rq[0], rq[1]})
    rd(8'h22, 4);
    `CHK("rd_wide", 32'hc322_00dd, {rq[0], rq[1], rq[2], rq[3]})
    rd(`AICS_SUB_BUS_ADDR, 4);
    `CHK("rd_addr", 32'h0000_0036, {rq[0], rq[1], rq[2], rq[3]})
    q = {8'h00, 8'h00, 8'h00, 8'h38};
    wr(`AICS_ADDR_SEL_HI, `AICS_SUB_BUS_ADDR);
    `CHK("locked", `AICS_ADDR_SEL_HI, bus_addr)
    q = {8'hf9, 8'ha5, 8'ha5, 8'ha5};
    wr(`AICS_ADDR_SEL_HI, `AICS_SUB_ADDR_EN);
    q = {8'h00, 8'h00, 8'h00, 8'h38};
    wr(`AICS_ADDR_SEL_HI, `AICS_SUB_BUS_ADDR);
    q = {8'h77};
    wr(7'h1c, 8'h04);
    `CHK("new_addr", {7'h1c, 1'b1, 8'h77}, {bus_addr, ack, wr_data[7:0]})
    conclude;
  end
endmodule
